// file: bench/fcs_core_model.sv
// Integer core model issuing operation events
`timescale 1ns/100ps
module fcs_core_model import fcs_pkg::*; (
  input wire logic core_clk,
  input wire logic issue,
  input wire fcs_op_t req,
  output fcs_op_t op
);
  // Each event stands for exactly one cycle
  always @(posedge core_clk) begin
    op <= issue ? req : '0;
  end
endmodule // fcs_core_model

// file: bench/tb_fcs_core.sv
// Self-checking testbench for the FPU control and state logic
`timescale 1ns/100ps
module tb_fcs_core import fcs_pkg::*; ;
  logic core_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, issue = 0, irq, fp_err_ext, wb_ack_o;
  logic [7:0] adr = 0, last_vec = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rd, wb_dat_o;
  logic [639:0] regs = '0;
  logic [79:0] v;
  logic [2:0] idx = 0;
  logic [1:0] operand_class;
  logic [15:0] tag_store_word, tw, ex;
  logic [15:0] pre [4] = '{16'h0000, 16'h0400, 16'h0000, 16'h0200};
  logic [15:0] fx [4] = '{16'h0400, 16'h0000, 16'h0241, 16'h0041};
  fcs_op_t req = '0, op, o;
  fcs_trap_t trap;
  int fails = 0, check_count = 0, cyc_n = 0, seed = 14, ext_n = 0, trap_n = 0, t;
  fcs_core_model model (.core_clk(core_clk), .issue(issue), .req(req), .op(op));
  fcs_core dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op(op),
    .data_regs(regs), .operand_idx(idx), .operand_class(operand_class), .tag_store_word(tag_store_word),
    .trap(trap), .fp_err_ext(fp_err_ext), .irq(irq));
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc_n++;
    if (trap.valid === 1'b1) begin
      last_vec <= trap.vector;
      trap_n++;
    end
    if (fp_err_ext === 1'b1) ext_n++;
    if (cyc_n == 20000) begin
      fails++;
      end_sim;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(nm, rd, e);
  endtask
  task automatic fire(input fcs_op_t f);
    @(posedge core_clk);
    req <= f; issue <= 1;
    @(posedge core_clk);
    issue <= 0;
    repeat (4) @(posedge core_clk);
  endtask
  function automatic logic [1:0] cls(input logic [79:0] x, input logic e);
    if (e) return TAG_EMPTY;
    if (x[78:64] == 0 && x[63:0] == 0) return TAG_ZERO;
    if (x[78:64] == 15'h7FFF || x[78:64] == 0 || !x[63]) return TAG_SPECIAL;
    return TAG_VALID;
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1;
    rdchk("sysctl", OFF_SYSCTL, 32'h0000_0010);
    rdchk("fcw", OFF_FCW, 32'h0000_037F);
    wb(1, OFF_SYSCTL, 32'h0000_0000);
    rdchk("type", OFF_SYSCTL, 32'h0000_0010);
    wb(1, OFF_SYSCTL, 32'h0000_0002);
    o = '0; o.hw_wait = 1; fire(o);
    chk("no trap", trap_n, 0);
    wb(1, OFF_SYSCTL, 32'h0000_000A);
    fire(o);
    chk("vec7", last_vec, VEC_DEV_NA);
    wb(1, OFF_SYSCTL, 32'h0000_0022);
    o = '0; o.fp_exception = 1; fire(o);
    chk("vec16", last_vec, VEC_FP_ERR);
    chk("no ext", ext_n, 0);
    wb(1, OFF_SYSCTL, 32'h0000_0002);
    t = trap_n; fire(o);
    chk("ext", ext_n, 1);
    chk("no int", trap_n, t);
    rdchk("stat", OFF_IRQ_STAT, 32'h0000_0003);
    wb(1, OFF_IRQ_MASK, 32'h0000_0004); repeat (3) @(posedge core_clk);
    chk("irq off", irq, 0);
    wb(1, OFF_IRQ_MASK, 32'h0000_0007); repeat (3) @(posedge core_clk);
    chk("irq on", irq, 1);
    wb(1, OFF_IRQ_STAT, 32'h0000_0003); repeat (3) @(posedge core_clk);
    chk("irq clr", irq, 0);
    wb(1, OFF_FSW, 32'h0000_4700);
    o = '0; o.init = 1; fire(o);
    rdchk("fsw init", OFF_FSW, 32'h0000_0000);
    rdchk("tag init", OFF_TAG, 32'h0000_FFFF);
    wb(1, OFF_FSW, 32'h0000_4700);
    o = '0; o.rem_incomplete = 1; fire(o);
    rdchk("rem", OFF_FSW, 32'h0000_0400);
    for (int k = 0; k < 4; k++) begin
      wb(1, OFF_FSW, pre[k]);
      o = '0; o.tan_result = (k < 2); o.tan_out_of_range = (k == 0);
      o.stack_fault = (k > 1); o.stack_overflow = (k == 2); fire(o);
      rdchk("fsw op", OFF_FSW, fx[k]);
    end
    rdchk("stat stk", OFF_IRQ_STAT, 32'h0000_0004);
    wb(1, OFF_FCW, 32'h0000_137F);
    rdchk("inf", OFF_FCW, 32'h0000_137F);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 8; i++) begin
        v = 80'({$random(seed), $random(seed), $random(seed)});
        case ($random(seed) & 3)
          0: v = '0;
          1: v[78:63] = 16'h7FFF;
          2: v[78:63] = 16'h2468;
          default: v[78:64] = 15'h7FFF;
        endcase
        regs[80*i+:80] <= v;
      end
      tw = (r == 0) ? 16'hE4E4 : (r == 1) ? 16'h1B1B : 16'($random(seed));
      o = '0; o.tag_load = 1; o.tag_load_word = tw; fire(o);
      for (int i = 0; i < 8; i++) begin
        @(posedge core_clk);
        idx <= 3'(i);
        repeat (3) @(posedge core_clk);
        ex[2*i+:2] = cls(regs[80*i+:80], tw[2*i+:2] == TAG_EMPTY);
        chk("class", operand_class, ex[2*i+:2]);
      end
      o = '0; o.tag_store = 1; fire(o);
      chk("tag store", tag_store_word, ex);
      rdchk("tag rd", OFF_TAG, {16'h0000, ex});
    end
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    wb(1, OFF_SYSCTL, 32'h0000_0022);
    rdchk("ne set", OFF_SYSCTL, 32'h0000_0032);
    @(posedge core_clk);
    rst_b <= 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    rdchk("ne reset", OFF_SYSCTL, 32'h0000_0010);
    chk("tsw reset", tag_store_word, 32'h0000_FFFF);
    end_sim;
  end
endmodule // tb_fcs_core

// file: rtl/fcs_core.sv
// FPU control and state logic with Wishbone register access
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module fcs_core import fcs_pkg::*; #(
  parameter int NREG = NUM_REGS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire fcs_op_t op,
  input wire logic [80*NREG-1:0] data_regs,
  input wire logic [2:0] operand_idx,
  output logic [1:0] operand_class,
  output logic [15:0] tag_store_word,
  output fcs_trap_t trap,
  output logic fp_err_ext,
  output logic irq
);
  logic [5:0] sysctl;
  logic [15:0] fcw;
  logic [15:0] fsw;
  logic [NREG-1:0] nonempty;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2*NREG-1:0] tag_calc;
  logic [2*NREG-1:0] tag_view;
  logic wb_req;
  logic wb_wr;
  logic [2:0] ev;
  logic wait_trap;

  // Tags computed from each register's contents and occupancy
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_tag
      fcs_tag_class u_cls (
        .value(data_regs[80*g +: 80]),
        .empty(!nonempty[g]),
        .tag(tag_calc[2*g +: 2])
      );
    end
  endgenerate
  assign tag_view = tag_calc;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wait_trap = op.hw_wait && sysctl[BIT_MONITOR] && sysctl[BIT_TASKSW];
  assign ev[IRQ_FP_EXT] = op.fp_exception && !sysctl[BIT_NATIVE_ERR];
  assign ev[IRQ_DEV_NA] = wait_trap;
  assign ev[IRQ_STACK] = op.stack_fault;

  // Bus acknowledge, one cycle after request
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        OFF_SYSCTL: wb_dat_o <= {26'h0, sysctl};
        OFF_FCW: wb_dat_o <= {16'h0000, fcw};
        OFF_FSW: wb_dat_o <= {16'h0000, fsw};
        OFF_TAG: wb_dat_o <= {16'h0000, tag_view};
        OFF_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
        OFF_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // System control word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sysctl <= SYSCTL_RST;
    end else if (wb_wr && wb_adr_i == OFF_SYSCTL && wb_sel_i[0]) begin
      sysctl <= wb_dat_i[5:0];
      sysctl[BIT_COPROC_TYPE] <= 1'b1;
      sysctl[0] <= 1'b0;
      sysctl[2] <= 1'b0;
    end
  end

  // Control word; infinity bit kept only for readback
  always_ff @(posedge core_clk) begin
    if (!rst_b || op.init) begin
      fcw <= FCW_RST;
    end else if (wb_wr && wb_adr_i == OFF_FCW) begin
      if (wb_sel_i[0]) fcw[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) fcw[15:8] <= wb_dat_i[15:8];
    end
  end

  // Status word
  always_ff @(posedge core_clk) begin
    if (!rst_b || op.init) begin
      fsw <= FSW_RST;
    end else begin
      if (wb_wr && wb_adr_i == OFF_FSW) begin
        if (wb_sel_i[0]) fsw[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) fsw[15:8] <= wb_dat_i[15:8];
      end
      if (op.rem_incomplete) begin
        fsw[BIT_CC0] <= 1'b0;
        fsw[BIT_CC1] <= 1'b0;
        fsw[BIT_CC3] <= 1'b0;
      end
      if (op.tan_result) begin
        fsw[BIT_CC2] <= op.tan_out_of_range;
      end
      if (op.stack_fault) begin
        fsw[BIT_INVALID] <= 1'b1;
        fsw[BIT_STACK_FAULT] <= 1'b1;
        fsw[BIT_CC1] <= op.stack_overflow;
      end
    end
  end

  // Occupancy reduced from loaded tags
  always_ff @(posedge core_clk) begin
    if (!rst_b || op.init) begin
      nonempty <= '0;
    end else if (op.tag_load) begin
      for (int i = 0; i < NREG; i++) begin
        nonempty[i] <= op.tag_load_word[2*i +: 2] != TAG_EMPTY;
      end
    end
  end

  // Operand class and stored tag word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      operand_class <= TAG_EMPTY;
      tag_store_word <= TAG_RST;
    end else begin
      operand_class <= tag_calc[2*operand_idx +: 2];
      if (op.tag_store) begin
        tag_store_word <= tag_calc;
      end
    end
  end

  // Exception delivery to the core
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trap <= '0;
      fp_err_ext <= 1'b0;
    end else begin
      trap.valid <= wait_trap || (op.fp_exception && sysctl[BIT_NATIVE_ERR]);
      trap.vector <= wait_trap ? VEC_DEV_NA : VEC_FP_ERR;
      fp_err_ext <= op.fp_exception && !sysctl[BIT_NATIVE_ERR];
    end
  end

  // Interrupt status, mask and output; set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == OFF_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat <= (irq_stat & ~wb_dat_i[2:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wb_wr && wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[2:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Checks
  a_ctype_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 sysctl[BIT_COPROC_TYPE]) else $error("type flag low");
  a_native_vec: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.fp_exception && sysctl[BIT_NATIVE_ERR] && !wait_trap |=> trap.valid && trap.vector == VEC_FP_ERR)
    else $error("no vector 16");
  a_ext_report: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.fp_exception && !sysctl[BIT_NATIVE_ERR] |=> fp_err_ext) else $error("no external report");
  a_ne_reset: assert property (@(posedge core_clk)
    !rst_b |=> !sysctl[BIT_NATIVE_ERR]) else $error("native flag after reset");
  a_wait_trap: assert property (@(posedge core_clk) disable iff (!rst_b)
    wait_trap |=> trap.valid && trap.vector == VEC_DEV_NA) else $error("no vector 7");
  a_cc_init: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.init |=> fsw[BIT_CC0] == 1'b0 && fsw[BIT_CC1] == 1'b0 && fsw[BIT_CC2] == 1'b0 && fsw[BIT_CC3] == 1'b0)
    else $error("codes not cleared");
  a_rem_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.rem_incomplete && !op.stack_fault |=> !fsw[BIT_CC0] && !fsw[BIT_CC1] && !fsw[BIT_CC3])
    else $error("remainder codes");
  a_tan_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.tan_result && !op.init |=> fsw[BIT_CC2] == $past(op.tan_out_of_range)) else $error("tangent flag");
  a_stack_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.stack_fault && !op.init |=> fsw[BIT_INVALID] && fsw[BIT_STACK_FAULT] && fsw[BIT_CC1] == $past(op.stack_overflow))
    else $error("stack fault bits");
  a_tag_empty: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.tag_load && !op.init && op.tag_load_word[1:0] == TAG_EMPTY |=> !nonempty[0]) else $error("tag reduce");
  a_init_tags: assert property (@(posedge core_clk) disable iff (!rst_b)
    op.init |=> tag_view == TAG_RST) else $error("tags after init");
endmodule // fcs_core

// file: rtl/fcs_pkg.sv
// Package for the FPU control and state logic
package fcs_pkg;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] OFF_SYSCTL = 8'h00;
  localparam logic [7:0] OFF_FCW = 8'h04;
  localparam logic [7:0] OFF_FSW = 8'h08;
  localparam logic [7:0] OFF_TAG = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // System control word field positions
  localparam int BIT_MONITOR = 1;
  localparam int BIT_TASKSW = 3;
  localparam int BIT_COPROC_TYPE = 4;
  localparam int BIT_NATIVE_ERR = 5;
  // Status word field positions
  localparam int BIT_INVALID = 0;
  localparam int BIT_STACK_FAULT = 6;
  localparam int BIT_CC0 = 8;
  localparam int BIT_CC1 = 9;
  localparam int BIT_CC2 = 10;
  localparam int BIT_CC3 = 14;
  // Control word infinity bit
  localparam int BIT_INF_CTL = 12;
  // Reset values
  localparam logic [5:0] SYSCTL_RST = 6'h10;
  localparam logic [15:0] FCW_RST = 16'h037F;
  localparam logic [15:0] FSW_RST = 16'h0000;
  localparam logic [15:0] TAG_RST = 16'hFFFF;
  // Exception vectors
  localparam logic [7:0] VEC_FP_ERR = 8'h10;
  localparam logic [7:0] VEC_DEV_NA = 8'h07;
  // Tag codes
  localparam logic [1:0] TAG_VALID = 2'b00;
  localparam logic [1:0] TAG_ZERO = 2'b01;
  localparam logic [1:0] TAG_SPECIAL = 2'b10;
  localparam logic [1:0] TAG_EMPTY = 2'b11;
  localparam int NUM_REGS = 8;
  // Interrupt status bits
  localparam int IRQ_FP_EXT = 0;
  localparam int IRQ_DEV_NA = 1;
  localparam int IRQ_STACK = 2;

  // Core operation events
  typedef struct packed {
    logic init;
    logic hw_wait;
    logic rem_incomplete;
    logic tan_result;
    logic tan_out_of_range;
    logic stack_fault;
    logic stack_overflow;
    logic fp_exception;
    logic tag_load;
    logic [15:0] tag_load_word;
    logic tag_store;
  } fcs_op_t;

  // Trap answer to the core
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } fcs_trap_t;
endpackage

// file: rtl/fcs_tag_class.sv
// Classifier of one 80-bit data register into a tag code
`timescale 1ns/100ps
module fcs_tag_class import fcs_pkg::*; (
  input wire logic [79:0] value,
  input wire logic empty,
  output logic [1:0] tag
);
  logic [14:0] expo;
  logic [63:0] mant;
  assign expo = value[78:64];
  assign mant = value[63:0];
  always_comb begin
    if (empty) begin
      tag = TAG_EMPTY;
    end else if (expo == 15'h0000 && mant == 64'h0) begin
      tag = TAG_ZERO;
    end else if (expo == 15'h7FFF || expo == 15'h0000) begin
      tag = TAG_SPECIAL;
    end else if (!mant[63]) begin
      tag = TAG_SPECIAL;
    end else begin
      tag = TAG_VALID;
    end
  end
endmodule // fcs_tag_class
